// file: hdl/arpwm_pkg.sv
// arpwm_pkg: register map, field positions and carrier types of the auto-reload pwm timer
// assumes an 8-bit register port with word indices as addresses
package arpwm_pkg;
  localparam int          ARPWM_AW        = 4;
  localparam int          ARPWM_DW        = 8;
  localparam int          ARPWM_NCH       = 4;
  localparam int          ARPWM_NCAP      = 2;
  // register indices
  localparam logic [3:0]  ADDR_DUTY3      = 4'h3;
  localparam logic [3:0]  ADDR_DUTY2      = 4'h4;
  localparam logic [3:0]  ADDR_DUTY1      = 4'h5;
  localparam logic [3:0]  ADDR_DUTY0      = 4'h6;
  localparam logic [3:0]  ADDR_PWMCTL     = 4'h7;
  localparam logic [3:0]  ADDR_CSR        = 4'h8;
  localparam logic [3:0]  ADDR_CNT        = 4'h9;
  localparam logic [3:0]  ADDR_RELOAD     = 4'hA;
  localparam logic [3:0]  ADDR_CAPCSR     = 4'hB;
  localparam logic [3:0]  ADDR_CAP1       = 4'hC;
  localparam logic [3:0]  ADDR_CAP2       = 4'hD;
  // control/status fields
  localparam int          CSR_OVF         = 0;
  localparam int          CSR_OIE         = 1;
  localparam int          CSR_FRL         = 2;
  localparam int          CSR_CEN         = 3;
  localparam int          CSR_DIV_LO      = 4;
  localparam int          CSR_CLKSRC      = 7;
  localparam int          PWMCTL_OE_LO    = 4;
  localparam int          CAP_FLAG_LO     = 0;
  localparam int          CAP_IE_LO       = 2;
  localparam int          CAP_EDGE_LO     = 4;
  localparam logic [7:0]  REG_RESET       = 8'h00;
  localparam logic [7:0]  CNT_TOP         = 8'hFF;
  localparam logic [6:0]  PRE_RESET       = 7'h00;

  typedef struct packed {
    logic [ARPWM_AW-1:0] addr;
    logic [ARPWM_DW-1:0] wdata;
    logic                wr;
    logic                rd;
  } arpwm_bus_s;
endpackage

// file: hdl/arpwm_timer.sv
// arpwm_timer: 8-bit auto-reload counter, 7-bit prescaler, four pwm outputs, two captures
// assumes register strobes synchronous to REF_CLK; pins and external clock asynchronous
`timescale 1ns/100ps
// Summary of operation
// RULE1: all channels share period count/(256-reload)
// RULE2: overflow drives outputs to polarity start level
// RULE3: compare match restores opposite level
// RULE4: polarity bit inverts levels, immediately
// RULE5: enable bits route channel onto pin
// RULE6: pwm stops during halt
// RULE7: software keeps compare above reload value
// RULE8: overflow sets flag, irq when enabled
// RULE9: flag marks FFh to reload; read clears
// RULE10: event mode counts external edges to overflow
// RULE11: software clears counter enable before halt
// RULE12: clock source bit picks cpu or external
// RULE13: divide field selects power-of-two tap
// RULE14: counter enable clear freezes prescaler, counter
// RULE15: force reload loads counter, clears prescaler
// RULE16: counter register reads live, writes counter
// RULE17: overflow reloads from auto-reload register
// RULE18: active capture edge latches counter, sets flag
// RULE19: capture blocked until read; read clears flag
// RULE20: capture irq held while flag and enable
// RULE21: enabled capture edge in halt wakes cpu
// RULE22: duty register sets second edge per channel
// RULE23: compare shadow loaded only at overflow
// RULE24: counter increments on prescaler output edge
// RULE25: reset clears counter, prescaler, selects cpu clock
// RULE26: counter write also clears prescaler
// RULE27: overflow beats simultaneous flag-clearing read
module arpwm_timer (
  // clock and reset
  input  wire logic                          REF_CLK,
  input  wire logic                          RST,
  // register port
  input  wire arpwm_pkg::arpwm_bus_s         BUS,
  output logic [arpwm_pkg::ARPWM_DW-1:0]     RDATA,
  // power mode
  input  wire logic                          HALT,
  // pins
  input  wire logic                          EXT_CLK_IN,
  input  wire logic [arpwm_pkg::ARPWM_NCAP-1:0] CAPTURE_IN_N,
  output logic [arpwm_pkg::ARPWM_NCH-1:0]    PWM_OUT_N,
  output logic [arpwm_pkg::ARPWM_NCH-1:0]    PWM_OE,
  // interrupt requests
  output logic                               OVF_IRQ,
  output logic [arpwm_pkg::ARPWM_NCAP-1:0]   CAP_IRQ,
  output logic                               WAKEUP
);
  import arpwm_pkg::*;

  localparam int NCH  = ARPWM_NCH;
  localparam int NCAP = ARPWM_NCAP;

  logic [7:0]      csr_reg;
  logic [7:0]      reload_reg;
  logic [7:0]      pwmctl_reg;
  logic [7:0]      duty_reg [NCH];
  logic [7:0]      shadow_reg [NCH];
  logic [7:0]      cnt_reg;
  logic [6:0]      pre_reg;
  logic [NCAP-1:0] cap_edge_reg;
  logic [NCAP-1:0] cap_ie_reg;
  logic [NCAP-1:0] cap_flag_reg;
  logic [7:0]      cap_val_reg [NCAP];
  logic [1:0]      ext_sync_reg;
  logic            ext_prev_reg;
  logic [NCAP-1:0] cap_s1_reg;
  logic [NCAP-1:0] cap_s2_reg;
  logic [NCAP-1:0] cap_prev_reg;
  logic [NCH-1:0]  level_reg;

  // register decode
  wire wr_csr    = BUS.wr && (BUS.addr == ADDR_CSR);
  wire wr_cnt    = BUS.wr && (BUS.addr == ADDR_CNT);
  wire wr_reload = BUS.wr && (BUS.addr == ADDR_RELOAD);
  wire wr_pwmctl = BUS.wr && (BUS.addr == ADDR_PWMCTL);
  wire wr_capcsr = BUS.wr && (BUS.addr == ADDR_CAPCSR);
  wire rd_csr    = BUS.rd && (BUS.addr == ADDR_CSR);
  wire [NCAP-1:0] rd_cap = {BUS.rd && (BUS.addr == ADDR_CAP2), BUS.rd && (BUS.addr == ADDR_CAP1)};
  wire force_rl  = wr_csr && BUS.wdata[CSR_FRL];                                 // [RULE15]

  // clock source and prescaler tap
  wire ext_rise  = ext_sync_reg[1] && !ext_prev_reg;
  wire in_tick   = csr_reg[CSR_CLKSRC] ? ext_rise : 1'b1;                         // [RULE12] [RULE10]
  wire run       = csr_reg[CSR_CEN] && !HALT;                                     // [RULE14] [RULE6]
  wire [2:0] div = csr_reg[CSR_DIV_LO +: 3];
  wire [7:0] pre_mask = 8'((9'h001 << div) - 9'h001);
  wire [6:0] pre_inc  = pre_reg + 7'h01;
  wire cnt_tick  = run && in_tick && ((8'(pre_reg) & pre_mask) == pre_mask);     // [RULE13] [RULE24]
  wire overflow  = cnt_tick && (cnt_reg == CNT_TOP);

  // prescaler: cleared by force reload or counter write, frozen when stopped
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) pre_reg <= PRE_RESET;                                                // [RULE25]
    else if (force_rl || wr_cnt) pre_reg <= PRE_RESET;                            // [RULE26] [RULE15]
    else if (run && in_tick) pre_reg <= cnt_tick ? PRE_RESET : pre_inc;
  end

  // counter
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) cnt_reg <= REG_RESET;
    else if (wr_cnt) cnt_reg <= BUS.wdata;                                        // [RULE16]
    else if (force_rl) cnt_reg <= reload_reg;                                     // [RULE15]
    else if (overflow) cnt_reg <= reload_reg;                                     // [RULE17] [RULE1]
    else if (cnt_tick) cnt_reg <= cnt_reg + 8'h01;                                // [RULE24]
  end

  // control/status: force reload bit never stored
  wire [7:0] csr_wmask = ~(8'h01 << CSR_FRL) & ~(8'h01 << CSR_OVF);
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) csr_reg <= REG_RESET;                                                // [RULE25]
    else begin
      if (wr_csr) csr_reg <= (BUS.wdata & csr_wmask) | {7'h00, csr_reg[CSR_OVF]};
      if (overflow) csr_reg[CSR_OVF] <= 1'b1;                                     // [RULE8] [RULE27]
      else if (rd_csr) csr_reg[CSR_OVF] <= 1'b0;                                  // [RULE9]
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      reload_reg <= REG_RESET;
      pwmctl_reg <= REG_RESET;
    end else begin
      if (wr_reload) reload_reg <= BUS.wdata;
      if (wr_pwmctl) pwmctl_reg <= BUS.wdata;
    end
  end

  // synchronisers
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ext_sync_reg <= 2'h0;
      ext_prev_reg <= 1'b0;
      cap_s1_reg   <= '1;
      cap_s2_reg   <= '1;
      cap_prev_reg <= '1;
    end else begin
      ext_sync_reg <= {ext_sync_reg[0], EXT_CLK_IN};
      ext_prev_reg <= ext_sync_reg[1];
      cap_s1_reg   <= CAPTURE_IN_N;
      cap_s2_reg   <= cap_s1_reg;
      cap_prev_reg <= cap_s2_reg;
    end
  end

  // pwm channels
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      localparam logic [3:0] DADDR = 4'(ADDR_DUTY0 - 4'(gi));
      wire wr_duty = BUS.wr && (BUS.addr == DADDR);
      wire match   = cnt_tick && !overflow && (cnt_reg == shadow_reg[gi]);
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          duty_reg[gi]   <= REG_RESET;
          shadow_reg[gi] <= REG_RESET;
          level_reg[gi]  <= 1'b1;
        end else begin
          if (wr_duty) duty_reg[gi] <= BUS.wdata;                                 // [RULE22]
          if (overflow) shadow_reg[gi] <= duty_reg[gi];                           // [RULE23]
          if (overflow) level_reg[gi] <= 1'b1;                                    // [RULE2]
          else if (match) level_reg[gi] <= 1'b0;                                  // [RULE3] [RULE7]
        end
      end
      // polarity applied after level so a change acts at once
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          PWM_OUT_N[gi] <= 1'b1;
          PWM_OE[gi]    <= 1'b0;
        end else begin
          PWM_OUT_N[gi] <= level_reg[gi] ^ pwmctl_reg[gi];                        // [RULE4]
          PWM_OE[gi]    <= pwmctl_reg[PWMCTL_OE_LO + gi] && !HALT;                // [RULE5] [RULE6]
        end
      end
    end
  endgenerate

  // capture channels
  generate
    for (gi = 0; gi < NCAP; gi++) begin : g_cap
      wire rise = cap_s2_reg[gi] && !cap_prev_reg[gi];
      wire fall = !cap_s2_reg[gi] && cap_prev_reg[gi];
      wire hit  = cap_edge_reg[gi] ? rise : fall;                                 // [RULE18]
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
          cap_flag_reg[gi] <= 1'b0;
          cap_val_reg[gi]  <= REG_RESET;
        end else if (hit && !cap_flag_reg[gi]) begin
          cap_flag_reg[gi] <= 1'b1;
          cap_val_reg[gi]  <= cnt_reg;
        end else if (rd_cap[gi]) begin
          cap_flag_reg[gi] <= 1'b0;                                               // [RULE19]
        end
      end
      always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) CAP_IRQ[gi] <= 1'b0;
        else CAP_IRQ[gi] <= (cap_flag_reg[gi] || hit) && cap_ie_reg[gi];          // [RULE20]
      end
    end
  endgenerate

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cap_edge_reg <= '0;
      cap_ie_reg   <= '0;
    end else if (wr_capcsr) begin
      cap_edge_reg <= BUS.wdata[CAP_EDGE_LO +: NCAP];
      cap_ie_reg   <= BUS.wdata[CAP_IE_LO +: NCAP];
    end
  end

  wire [NCAP-1:0] cap_hit_now = {g_cap[1].hit, g_cap[0].hit};
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      OVF_IRQ <= 1'b0;
      WAKEUP  <= 1'b0;
    end else begin
      OVF_IRQ <= (csr_reg[CSR_OVF] || overflow) && csr_reg[CSR_OIE];              // [RULE8]
      WAKEUP  <= HALT && |(cap_hit_now & cap_ie_reg);                             // [RULE21]
    end
  end

  // read mux
  wire [7:0] csr_rd = csr_reg & ~(8'h01 << CSR_FRL);
  wire [7:0] cap_rd = 8'({cap_edge_reg, cap_ie_reg, cap_flag_reg});
  logic [7:0] rd_mux;
  always_comb begin
    unique case (BUS.addr)
      ADDR_DUTY3:  rd_mux = duty_reg[3];
      ADDR_DUTY2:  rd_mux = duty_reg[2];
      ADDR_DUTY1:  rd_mux = duty_reg[1];
      ADDR_DUTY0:  rd_mux = duty_reg[0];
      ADDR_PWMCTL: rd_mux = pwmctl_reg;
      ADDR_CSR:    rd_mux = csr_rd;
      ADDR_CNT:    rd_mux = cnt_reg;                                              // [RULE16]
      ADDR_RELOAD: rd_mux = reload_reg;
      ADDR_CAPCSR: rd_mux = cap_rd;
      ADDR_CAP1:   rd_mux = cap_val_reg[0];
      ADDR_CAP2:   rd_mux = cap_val_reg[1];
      default:     rd_mux = REG_RESET;
    endcase
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) RDATA <= REG_RESET;
    else if (BUS.rd) RDATA <= rd_mux;
    else RDATA <= REG_RESET;
  end

  // ticks since the last overflow; a period is clean when no write disturbed it
  logic [8:0] period_tick_reg;
  logic       period_clean_reg;
  wire        period_upset = wr_cnt || force_rl || wr_reload;
  wire [8:0]  period_want  = 9'(CNT_TOP) + 9'h001 - {1'b0, reload_reg};            // [RULE1]
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      period_tick_reg  <= '0;
      period_clean_reg <= 1'b0;
    end else begin
      if (overflow) period_tick_reg <= 9'h001;
      else if (cnt_tick) period_tick_reg <= period_tick_reg + 9'h001;
      if (period_upset) period_clean_reg <= 1'b0;
      else if (overflow) period_clean_reg <= 1'b1;
    end
  end

  // checks
  ovf_flag_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE8]
    overflow |=> csr_reg[CSR_OVF])
    else $error("overflow did not set flag");

  ovf_race_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE27]
    overflow && rd_csr |=> csr_reg[CSR_OVF])
    else $error("flag lost to a clearing read");

  ovf_clear_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE9]
    rd_csr && !overflow |=> !csr_reg[CSR_OVF])
    else $error("flag not cleared by read");

  irq_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE8]
    csr_reg[CSR_OVF] && csr_reg[CSR_OIE] |=> OVF_IRQ)
    else $error("irq missing");

  irq_quiet_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE8]
    !csr_reg[CSR_OIE] |=> !OVF_IRQ)
    else $error("irq while disabled");

  reload_load_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE17]
    overflow && !wr_cnt && !force_rl |=> cnt_reg == $past(reload_reg))
    else $error("no reload");

  force_rl_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE15]
    force_rl && !wr_cnt |=> cnt_reg == $past(reload_reg) && pre_reg == PRE_RESET)
    else $error("force reload");

  frl_read_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE15]
    rd_csr |=> !RDATA[CSR_FRL])
    else $error("force reload bit read back");

  cnt_write_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE26]
    wr_cnt |=> cnt_reg == $past(BUS.wdata) && pre_reg == PRE_RESET)
    else $error("counter write");

  cnt_read_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE16]
    BUS.rd && (BUS.addr == ADDR_CNT) |=> RDATA == $past(cnt_reg))
    else $error("counter read not live");

  rdata_zero_a: assert property (@(posedge REF_CLK) disable iff (RST)
    !BUS.rd |=> RDATA == REG_RESET)
    else $error("read data without read");

  cnt_step_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE24]
    cnt_tick && !overflow && !wr_cnt && !force_rl |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("counter step");

  ext_gate_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE12]
    csr_reg[CSR_CLKSRC] && !ext_rise |-> !cnt_tick)
    else $error("tick without external edge");

  freeze_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE14]
    !run && !wr_cnt && !force_rl |=> $stable(cnt_reg) && $stable(pre_reg))
    else $error("not frozen");

  period_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE1]
    overflow && period_clean_reg |-> period_tick_reg == period_want)
    else $error("period length");

  shadow_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE23]
    !overflow |=> $stable(shadow_reg[0]))
    else $error("shadow changed");

  start_level_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE2]
    overflow |=> level_reg == '1)
    else $error("start level");

  match_level_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE3]
    g_chan[0].match |=> !level_reg[0])
    else $error("compare level");

  pol_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE4]
    1'b1 |=> PWM_OUT_N[0] == ($past(level_reg[0]) ^ $past(pwmctl_reg[0])))
    else $error("polarity");

  oe_route_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE5]
    !HALT |=> PWM_OE == $past(pwmctl_reg[PWMCTL_OE_LO +: NCH]))
    else $error("output enable routing");

  oe_halt_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE6]
    HALT |=> PWM_OE == '0)
    else $error("outputs driven in halt");

  cap_take_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE18]
    g_cap[0].hit && !cap_flag_reg[0] |=> cap_flag_reg[0] && cap_val_reg[0] == $past(cnt_reg))
    else $error("capture not taken");

  cap_block_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE19]
    cap_flag_reg[0] && !rd_cap[0] |=> $stable(cap_val_reg[0]) && cap_flag_reg[0])
    else $error("capture overwritten");

  cap_clear_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE19]
    rd_cap[0] && cap_flag_reg[0] |=> !cap_flag_reg[0])
    else $error("capture flag not cleared");

  cap_irq_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE20]
    cap_flag_reg[0] && cap_ie_reg[0] |=> CAP_IRQ[0])
    else $error("capture irq missing");

  wake_a: assert property (@(posedge REF_CLK) disable iff (RST) // [RULE21]
    HALT && g_cap[0].hit && cap_ie_reg[0] |=> WAKEUP)
    else $error("no wakeup");

  // main scenarios
  ovf_c: cover property (@(posedge REF_CLK) disable iff (RST) overflow && csr_reg[CSR_OIE]);
  match_c: cover property (@(posedge REF_CLK) disable iff (RST) g_chan[0].match);
  cap_c: cover property (@(posedge REF_CLK) disable iff (RST) g_cap[0].hit && !cap_flag_reg[0]);
  ext_c: cover property (@(posedge REF_CLK) disable iff (RST) overflow && csr_reg[CSR_CLKSRC]);
  wake_c: cover property (@(posedge REF_CLK) disable iff (RST) WAKEUP);
endmodule // arpwm_timer

// file: testbench/arpwm_pin_model.sv
// arpwm_pin_model: external event clock and capture pins seen by the timer
// assumes requests from the bench on the rising edge of clk
`timescale 1ns/100ps
module arpwm_pin_model (
  // clock
  input  wire logic       clk,
  // requests from the bench
  input  wire logic [3:0] event_count,
  input  wire logic       event_start,
  input  wire logic [1:0] capture_level,
  // pins
  output logic            external_clock_in = 1'b0,
  output logic [1:0]      capture_in_n
);
  assign capture_in_n = capture_level;
  // slow pulses so the synchroniser sees every event edge
  always @(posedge clk) begin
    if (event_start) begin
      for (int i = 0; i < event_count; i++) begin
        external_clock_in <= 1'b1;
        repeat (4) @(posedge clk);
        external_clock_in <= 1'b0;
        repeat (4) @(posedge clk);
      end
    end
  end
endmodule // arpwm_pin_model

// file: testbench/auto_reload_pwm_timer_test.sv
// auto_reload_pwm_timer_test: register-level tests of the pwm timer
// assumes the timer and the pin model; bus driven at rising edges
`timescale 1ns/100ps
module auto_reload_pwm_timer_test;
  import arpwm_pkg::*;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             halt = 1'b0;
  arpwm_bus_s       bus = '0;
  logic [7:0]       rdata;
  logic [3:0]       pwm_n, oe;
  logic             ovf_irq, wakeup;
  logic [1:0]       cap_irq, cap_n, cap_lvl = 2'b11;
  logic             ext_clk, ev_go = 1'b0;
  logic [3:0]       ev_cnt = 4'h0;
  logic [7:0]       d;
  int               num_errors = 0, comparisons = 0, r, h0, h1, h2, k;
  arpwm_timer arpwm_timer_inst (.REF_CLK(clk), .RST(rst), .BUS(bus), .RDATA(rdata), .HALT(halt),
    .EXT_CLK_IN(ext_clk), .CAPTURE_IN_N(cap_n), .PWM_OUT_N(pwm_n), .PWM_OE(oe),
    .OVF_IRQ(ovf_irq), .CAP_IRQ(cap_irq), .WAKEUP(wakeup));
  arpwm_pin_model arpwm_pin_model_inst (.clk(clk), .event_count(ev_cnt), .event_start(ev_go),
    .capture_level(cap_lvl), .external_clock_in(ext_clk), .capture_in_n(cap_n));
  initial begin
    forever #10 clk = ~clk;
  end
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= v;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    rd(a, d);
    chk(nm, e, d);
  endtask
  // counts rising edges and high cycles of one pwm output over n cycles
  task measure(input int ch, input int n, output int rises, output int highs);
    logic p;
    rises = 0;
    highs = 0;
    @(negedge clk);
    p = pwm_n[ch];
    repeat (n) begin
      @(negedge clk);
      if (pwm_n[ch] === 1'b1) highs++;
      if (pwm_n[ch] === 1'b1 && p === 1'b0) rises++;
      p = pwm_n[ch];
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pwm level", 8'h0F, {4'h0, pwm_n});
    for (k = 3; k < 16; k++) rchk("reset value", k[3:0], 8'h00);
    wr(ADDR_CNT, 8'h5A);
    rchk("counter stopped", ADDR_CNT, 8'h5A);
    rchk("counter still", ADDR_CNT, 8'h5A);
    wr(4'hF, 8'hFF);
    rchk("unmapped", 4'hF, 8'h00);
    wr(ADDR_RELOAD, 8'hF0);
    wr(ADDR_CSR, 8'h04);
    rchk("force reload", ADDR_CNT, 8'hF0);
    rchk("csr", ADDR_CSR, 8'h00);
    $display("test registers done");
    wr(ADDR_RELOAD, 8'hFC);
    wr(ADDR_DUTY0, 8'hFD);
    wr(ADDR_PWMCTL, 8'h10);
    wr(ADDR_CSR, 8'h0E);
    repeat (8) @(posedge clk);
    measure(0, 40, r, h0);
    chk("pwm rises", 8'h0A, r[7:0]);
    chk("pwm highs", 8'h14, h0[7:0]);
    chk("pwm enables", 8'h01, {4'h0, oe});
    wr(ADDR_DUTY0, 8'hFE);
    repeat (8) @(posedge clk);
    measure(0, 40, r, h2);
    chk("wider duty", 8'h1E, h2[7:0]);
    wr(ADDR_PWMCTL, 8'h11);
    measure(0, 40, r, h1);
    chk("inverted highs", 8'h0A, h1[7:0]);
    wr(ADDR_PWMCTL, 8'h10);
    rchk("overflow flag", ADDR_CSR, 8'h0B);
    chk("overflow irq", 8'h01, {7'h0, ovf_irq});
    @(posedge clk);
    halt <= 1'b1;
    repeat (4) @(posedge clk);
    measure(0, 40, r, h1);
    chk("halt rises", 8'd0, r[7:0]);
    chk("halt enables", 8'h00, {4'h0, oe});
    @(posedge clk);
    halt <= 1'b0;
    wr(ADDR_CSR, 8'h02);
    rd(ADDR_CSR, d);
    rchk("flag cleared", ADDR_CSR, 8'h02);
    chk("irq cleared", 8'h00, {7'h0, ovf_irq});
    $display("test pwm done");
    for (k = 0; k < 8; k++) begin
      wr(ADDR_CSR, {1'b0, k[2:0], 4'hC});
      repeat (4 << k) @(posedge clk);
      measure(0, 16 << k, r, h1);
      chk("divided rises", 8'd4, r[7:0]);
    end
    $display("test divider done");
    wr(ADDR_CSR, 8'h00);
    wr(ADDR_CNT, 8'h33);
    wr(ADDR_CAPCSR, 8'h14);
    cap_lvl <= 2'b10;
    repeat (8) @(posedge clk);
    cap_lvl <= 2'b11;
    repeat (8) @(posedge clk);
    chk("capture irq", 8'h01, {6'h0, cap_irq});
    rchk("capture flag", ADDR_CAPCSR, 8'h15);
    wr(ADDR_CNT, 8'h44);
    cap_lvl <= 2'b10;
    repeat (8) @(posedge clk);
    cap_lvl <= 2'b11;
    repeat (8) @(posedge clk);
    rchk("capture held", ADDR_CAP1, 8'h33);
    rchk("capture read clears", ADDR_CAPCSR, 8'h14);
    chk("capture irq off", 8'h00, {6'h0, cap_irq});
    @(posedge clk);
    cap_lvl <= 2'b10;
    repeat (8) @(posedge clk);
    halt <= 1'b1;
    cap_lvl <= 2'b11;
    k = 0;
    while (wakeup !== 1'b1 && k < 12) begin
      @(negedge clk);
      k++;
    end
    chk("wakeup", 8'h01, {7'h0, wakeup});
    if (wakeup !== 1'b1) finish_test();
    @(posedge clk);
    halt <= 1'b0;
    rchk("wake capture", ADDR_CAP1, 8'h44);
    $display("test capture done");
    wr(ADDR_RELOAD, 8'hFD);
    wr(ADDR_CSR, 8'h84);
    rd(ADDR_CSR, d);
    wr(ADDR_CSR, 8'h88);
    ev_cnt <= 4'h2;
    ev_go <= 1'b1;
    @(posedge clk);
    ev_go <= 1'b0;
    repeat (30) @(posedge clk);
    rchk("two events", ADDR_CNT, 8'hFF);
    rchk("no flag yet", ADDR_CSR, 8'h88);
    @(posedge clk);
    ev_cnt <= 4'h1;
    ev_go <= 1'b1;
    @(posedge clk);
    ev_go <= 1'b0;
    repeat (20) @(posedge clk);
    rchk("third event", ADDR_CSR, 8'h89);
    rchk("reloaded", ADDR_CNT, 8'hFD);
    wr(ADDR_CSR, 8'h80);
    $display("test events done");
    finish_test();
  end
endmodule // auto_reload_pwm_timer_test
